// *** pfl_cfg_if.sv ***
/*
  Interface carrying configuration from the register block to the core.
  Assumes both ends share ref_clk.
*/
`timescale 1ns/1ps
interface pfl_cfg_if;
  logic [1:0] final_sel;      // Final scale code
  logic [2:0] wide_sel;       // Wide scale code
  logic [1:0] fdet_sel;       // Detect scale code
  logic pump_polarity_select; // Direction select
  logic [4:0] tol;            // Edge-count tolerance
  logic restart;              // One-cycle restart pulse
  modport src (output final_sel, wide_sel, fdet_sel, pump_polarity_select, tol, restart);
  modport dst (input final_sel, wide_sel, fdet_sel, pump_polarity_select, tol, restart);
endinterface : pfl_cfg_if

// *** pfl_checker_sva.sv ***
/*
  Concurrent checks on the pump outputs of the fast-lock sequencer.
  Assumes one ref_clk domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module pfl_checker
  import pfl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic comparator_up,
  input wire logic comparator_down,
  input wire logic fdet_en_q,
  input wire logic [5:0] fdet_scale_q,
  input wire logic cl_en_q,
  input wire logic cl_up_q,
  input wire logic cl_dn_q,
  input wire logic [3:0] cl_scale_q,
  input wire logic [1:0] pump_state_q
);
  // ======
  // Helpers
  // ======
  logic [1:0] prev_state_q; // State one cycle back, marks a state exit
  logic [7:0] eval_cnt_q; // Length of the current evaluation run
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Track state history; a counter keeps the window check cheap
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_state_q <= 2'h0;
      eval_cnt_q <= 8'h00;
    end else begin
      prev_state_q <= pump_state_q;
      eval_cnt_q <= (pump_state_q == PFL_EVAL) ? eval_cnt_q + 8'h01 : 8'h00;
    end
  end
  // ======
  // Sequences
  // ======
  sequence s_final;
    pump_state_q == PFL_FINAL;
  endsequence
  sequence s_eval_exit;
    prev_state_q == PFL_EVAL ##0 pump_state_q != PFL_EVAL;
  endsequence
  // ======
  // Assertions
  // ======
  excl_groups_a: assert property (!(fdet_en_q && cl_en_q))
    else $error("detect and closed-loop outputs both enabled");
  fdet_follow_a: assert property (fdet_en_q == (pump_state_q == PFL_FDET))
    else $error("detect enable does not follow state");
  cl_follow_a: assert property (cl_en_q == pump_state_q[1])
    else $error("closed-loop enable does not follow state");
  pump_steer_a: assert property (cl_en_q |->
    ({cl_up_q, cl_dn_q} == {$past(comparator_up), $past(comparator_down)}) ||
    ({cl_up_q, cl_dn_q} == {$past(comparator_down), $past(comparator_up)}))
    else $error("closed-loop pump not steered by comparator");
  pump_gate_a: assert property (!cl_en_q |-> !cl_up_q && !cl_dn_q)
    else $error("closed-loop pump active while disabled");
  fdet_scale_a: assert property (fdet_scale_q inside {6'h00, 6'h14, 6'h28, 6'h3C}
    && (fdet_en_q || fdet_scale_q == 6'h00))
    else $error("detect scale out of range");
  final_scale_a: assert property (pump_state_q == PFL_FINAL |->
    cl_scale_q inside {[4'h1:4'h4]})
    else $error("final scale out of range");
  wide_scale_a: assert property (pump_state_q == PFL_WIDE |->
    cl_scale_q != 4'h0 && !cl_scale_q[0])
    else $error("wide state with zero or odd scale");
  final_hold_a: assert property (s_final |=> pump_state_q inside {PFL_FINAL, PFL_EVAL})
    else $error("final state left without restart");
  window_len_a: assert property (s_eval_exit |-> eval_cnt_q inside {[8'h94:8'h9C]})
    else $error("evaluation window length wrong");
endmodule : pfl_checker

bind pll_fast_lock pfl_checker pfl_checker_i (.ref_clk, .reset_n, .comparator_up,
  .comparator_down, .fdet_en_q, .fdet_scale_q, .cl_en_q, .cl_up_q, .cl_dn_q,
  .cl_scale_q, .pump_state_q);

// *** pfl_edge_cnt.sv ***
/*
  Synchronises one detector input and counts its rising edges.
  Assumes the input is asynchronous to ref_clk and slower than half of it.
*/
`timescale 1ns/1ps
module pfl_edge_cnt (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sig_in,
  input wire logic clear,
  output logic [7:0] count
);
  import pfl_pkg::*;

  logic [2:0] sync_q;  // Two-flop synchroniser plus edge history

  // ==========================================================
  // Synchronise, then count edges from stage two onward only
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q <= 3'h0;
      count <= 8'h00;
    end else begin
      sync_q <= {sync_q[1:0], sig_in};
      // Counter saturates so a fast input cannot wrap into a false match
      if (clear) begin
        count <= {7'h00, (sync_q[1] & ~sync_q[2])};
      end else if ((sync_q[1] & ~sync_q[2]) && count != 8'hFF) begin
        count <= count + 8'h01;
      end
    end
  end
endmodule : pfl_edge_cnt

// *** pfl_loop_model.sv ***
/*
  Behavioural loop filter and oscillator: makes the reference and feedback
  edges and the phase lock indication. Assumes ref_clk and reset_n.
*/
`timescale 1ns/1ps
module pfl_loop_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic fdet_en_q,
  input wire logic fdet_src_q,
  input wire logic cl_en_q,
  input wire logic vco_inverted,
  input wire logic lock_allow,
  input wire logic preset,
  input wire logic [3:0] fb_init,
  output logic reference_detector_input,
  output logic feedback_detector_input,
  output logic phase_lock_in
);
  // ======
  // Oscillators
  // ======
  logic [3:0] fb_half_q; // Feedback half period in clocks
  logic [3:0] ref_cnt_q;
  logic [3:0] fb_cnt_q;
  logic [8:0] step_q; // Slow slew keeps a whole window at each frequency
  wire raise = fdet_src_q ^ vco_inverted; // Inverted oscillator turns the push round
  // Toggle both signals; slew feedback only under detect current
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fb_half_q <= 4'h8;
      ref_cnt_q <= 4'h0;
      fb_cnt_q <= 4'h0;
      step_q <= 9'h000;
      reference_detector_input <= 1'b0;
      feedback_detector_input <= 1'b0;
    end else begin
      ref_cnt_q <= (ref_cnt_q == 4'h3) ? 4'h0 : ref_cnt_q + 4'h1;
      if (ref_cnt_q == 4'h3) reference_detector_input <= ~reference_detector_input;
      fb_cnt_q <= (fb_cnt_q >= fb_half_q - 4'h1) ? 4'h0 : fb_cnt_q + 4'h1;
      if (fb_cnt_q >= fb_half_q - 4'h1) feedback_detector_input <= ~feedback_detector_input;
      if (preset) begin
        fb_half_q <= fb_init;
      end else if (fdet_en_q) begin
        step_q <= (step_q == 9'h13F) ? 9'h000 : step_q + 9'h001;
        if (step_q == 9'h13F && raise && fb_half_q > 4'h3) fb_half_q <= fb_half_q - 4'h1;
        if (step_q == 9'h13F && !raise && fb_half_q < 4'hC) fb_half_q <= fb_half_q + 4'h1;
      end
    end
  end
  // Lock shows only with the loop closed and the bench allowing it
  assign phase_lock_in = cl_en_q & lock_allow;
endmodule : pfl_loop_model

// *** pfl_pkg.sv ***
/*
  Package for the fast-lock sequencer: register map, field layout,
  reset values, timing counts and the state enumeration.
  Assumes a single 100 MHz clock domain and an AXI4-Lite register bus.
*/
// Behaviour
// - Pump always in exactly one of three states; code adds a fourth, idle PFL_EVAL
// - Detect state drives fixed current, not comparator
// - Frequency lock moves pump to closed loop
// - Closed loops follow comparator up/down decisions
// - Detect and closed-loop outputs enabled separately
// - Comparison runs at one eighth system clock
// - Lock judged over nineteen divided-clock cycles
// - Wide closed loop uses its programmed current
// - Wide moves to final on phase lock
// - Zero wide current skips straight to final
// - Per-state scaling of baseline pump current
// - Polarity bit reverses pump direction, default zero
package pfl_pkg;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [3:0] PFL_CTRL_OFS = 4'h0;    // Control: scalings, polarity, restart
  localparam logic [3:0] PFL_STAT_OFS = 4'h4;    // Status: state, frequency lock, phase lock
  localparam logic [3:0] PFL_TOL_OFS = 4'h8;     // Lock tolerance in edges

  // ==========================================================
  // Control field layout
  // ==========================================================
  localparam int PFL_FINAL_LSB = 0;     // 2 bits, scale 1..4
  localparam int PFL_WIDE_LSB = 2;      // 3 bits, scale 0..14 step 2
  localparam int PFL_FDET_LSB = 5;      // 2 bits, scale 0..60 step 20
  localparam int PFL_POL_BIT = 7;       // Pump polarity select
  localparam int PFL_RESTART_BIT = 8;   // Write one: restart acquisition

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] PFL_CTRL_RST = 8'h00;
  localparam logic [4:0] PFL_TOL_RST = 5'h01;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int PFL_DIV = 8;                          // Divided clock ratio
  localparam logic [2:0] PFL_DIV_LAST = 3'(PFL_DIV - 1);
  localparam logic [4:0] PFL_WIN_LAST = 5'h12;         // 19 divided cycles, 0..18

  // ==========================================================
  // Sequencer states
  // ==========================================================
  typedef enum logic [1:0] {
    PFL_EVAL  = 2'b00,  // First window, outputs idle
    PFL_FDET  = 2'b01,  // Frequency detect
    PFL_WIDE  = 2'b10,  // Wide closed loop
    PFL_FINAL = 2'b11   // Final closed loop
  } pfl_state_e;

endpackage : pfl_pkg

// *** pfl_regs.sv ***
/*
  AXI4-Lite slave holding control and tolerance, reading back status.
  Assumes one outstanding read and one outstanding write at a time.
*/
`timescale 1ns/1ps
module pfl_regs (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [31:0] status,
  pfl_cfg_if.src cfg
);
  import pfl_pkg::*;

  logic [3:0] aw_q;       // Captured write address
  logic aw_have_q;        // Write address held
  logic [31:0] w_q;       // Captured write data
  logic [3:0] ws_q;       // Captured strobes
  logic w_have_q;         // Write data held
  logic [7:0] ctrl_q;     // Control bits 7:0
  logic [4:0] tol_q;      // Tolerance
  logic restart_q;        // Restart pulse
  wire do_wr = aw_have_q & w_have_q & ~bvalid;  // Both halves present
  wire wr_ctrl = do_wr && aw_q == PFL_CTRL_OFS;
  wire wr_tol = do_wr && aw_q == PFL_TOL_OFS;
  wire wr_ok = aw_q == PFL_CTRL_OFS || aw_q == PFL_TOL_OFS || aw_q == PFL_STAT_OFS;
  wire rd_ok = araddr == PFL_CTRL_OFS || araddr == PFL_TOL_OFS || araddr == PFL_STAT_OFS;
  wire [31:0] rd_val = (araddr == PFL_CTRL_OFS) ? {24'h000000, ctrl_q} :
                       (araddr == PFL_TOL_OFS) ? {27'h0000000, tol_q} :
                       (araddr == PFL_STAT_OFS) ? status : 32'h00000000;

  assign cfg.final_sel = ctrl_q[PFL_FINAL_LSB +: 2];
  assign cfg.wide_sel = ctrl_q[PFL_WIDE_LSB +: 3];
  assign cfg.fdet_sel = ctrl_q[PFL_FDET_LSB +: 2];
  assign cfg.pump_polarity_select = ctrl_q[PFL_POL_BIT];
  assign cfg.tol = tol_q;
  assign cfg.restart = restart_q;

  // ==========================================================
  // Write channel: address and data accepted in either order
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready <= 1'b1;  // Ready flags are flops, so top outputs carry no logic
      wready <= 1'b1;
      aw_q <= 4'h0;
      w_q <= 32'h00000000;
      ws_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      if (awvalid && !aw_have_q) begin
        aw_q <= awaddr;
        aw_have_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && !w_have_q) begin
        w_q <= wdata;
        ws_q <= wstrb;
        w_have_q <= 1'b1;
        wready <= 1'b0;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b1;
        bresp <= wr_ok ? 2'h0 : 2'h2;  // SLVERR on unmapped address
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Register store; restart bit is write-one, self-clearing
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= PFL_CTRL_RST;
      tol_q <= PFL_TOL_RST;
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_ctrl && ws_q[1] && w_q[PFL_RESTART_BIT];
      if (wr_ctrl && ws_q[0]) begin
        ctrl_q <= w_q[7:0];
      end
      if (wr_tol && ws_q[0]) begin
        tol_q <= w_q[4:0];
      end
    end
  end

  // ==========================================================
  // Read channel: one cycle to answer
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      arready <= 1'b0;
      rdata <= rd_val;
      rresp <= rd_ok ? 2'h0 : 2'h2;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule : pfl_regs

// *** pll_fast_lock.sv ***
/*
  Top of the fast-lock sequencer: divided comparison clock, edge counts
  over a nineteen-cycle window, state machine and pump output steering.
  Assumes the detector inputs and lock indicator are asynchronous pins,
  and the comparator up/down decisions come from the same clock domain.
*/
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pll_fast_lock (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reference_detector_input,
  input wire logic feedback_detector_input,
  input wire logic phase_lock_in,
  input wire logic comparator_up,
  input wire logic comparator_down,
  input wire logic loop_disturb,
  output logic fdet_en_q,
  output logic fdet_src_q,
  output logic [5:0] fdet_scale_q,
  output logic cl_en_q,
  output logic cl_up_q,
  output logic cl_dn_q,
  output logic [3:0] cl_scale_q,
  output logic [1:0] pump_state_q
);
  import pfl_pkg::*;

  pfl_cfg_if cfg ();                // Configuration from registers

  logic [2:0] div_q;                // System clock divider by eight
  logic [4:0] win_q;                // Window position, divided cycles
  logic [1:0] lock_sync_q;          // Phase-lock synchroniser
  logic [1:0] dist_sync_q;          // Disturb synchroniser
  logic dist_prev_q;                // Disturb edge history
  logic freq_lock_q;                // Last window verdict
  logic ref_fast_q;                 // Reference outran feedback
  pfl_state_e state_q;              // Sequencer state
  pfl_state_e state_d;
  logic [7:0] ref_cnt;              // Reference edges this window
  logic [7:0] fb_cnt;               // Feedback edges this window
  logic [31:0] status;              // Status word for readback

  // ==========================================================
  // Decode helpers
  // ==========================================================
  // Scale codes expand into the per-state multipliers
  function automatic logic [3:0] wide_scale(input logic [2:0] code);
    wide_scale = {code, 1'b0};
  endfunction : wide_scale

  wire div_tick = div_q == PFL_DIV_LAST;
  wire win_end = div_tick && win_q == PFL_WIN_LAST;
  wire [7:0] diff = (ref_cnt > fb_cnt) ? ref_cnt - fb_cnt : fb_cnt - ref_cnt;
  wire win_lock = diff <= {3'h0, cfg.tol};
  wire ref_fast = ref_cnt > fb_cnt;
  wire dist_evt = dist_sync_q[1] & ~dist_prev_q;            // Rising disturb
  wire restart = cfg.restart | dist_evt;
  wire wide_zero = cfg.wide_sel == 3'h0;
  wire closed = state_q == PFL_WIDE || state_q == PFL_FINAL;
  // Polarity zero: feedback leading lowers the control node
  wire pol = cfg.pump_polarity_select;
  wire up_dir = pol ? comparator_down : comparator_up;
  wire dn_dir = pol ? comparator_up : comparator_down;
  // Feedback slow means the control node must rise at polarity zero
  wire fdet_raise = ref_fast_q ^ pol;
  wire [5:0] fdet_mult = 6'(20 * cfg.fdet_sel);
  wire [3:0] cl_mult = (state_q == PFL_WIDE) ? wide_scale(cfg.wide_sel)
                       : {2'h0, cfg.final_sel} + 4'h1;

  assign status = {26'h0, lock_sync_q[1], freq_lock_q, 2'h0, state_q};

  // ==========================================================
  // Register block and edge counters
  // ==========================================================
  pfl_regs u_regs (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .status(status),
    .cfg(cfg)
  );

  // Counts restart each window so the verdict reflects fresh edges
  pfl_edge_cnt u_ref_cnt (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sig_in(reference_detector_input),
    .clear(win_end | restart),
    .count(ref_cnt)
  );

  pfl_edge_cnt u_fb_cnt (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sig_in(feedback_detector_input),
    .clear(win_end | restart),
    .count(fb_cnt)
  );

  // ==========================================================
  // Divided clock tick and comparison window
  // ==========================================================
  // A tick enable keeps one clock domain; no derived clock is built
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 3'h0;
      win_q <= 5'h00;
    end else if (restart) begin
      div_q <= 3'h0;
      win_q <= 5'h00;
    end else begin
      div_q <= div_q + 3'h1;
      if (div_tick) begin
        win_q <= win_end ? 5'h00 : win_q + 5'h01;
      end
    end
  end

  // ==========================================================
  // Pin synchronisers and window verdict
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_sync_q <= 2'h0;
      dist_sync_q <= 2'h0;
      dist_prev_q <= 1'b0;
      freq_lock_q <= 1'b0;
      ref_fast_q <= 1'b0;
    end else begin
      lock_sync_q <= {lock_sync_q[0], phase_lock_in};
      dist_sync_q <= {dist_sync_q[0], loop_disturb};
      dist_prev_q <= dist_sync_q[1];
      if (win_end) begin
        freq_lock_q <= win_lock;
        ref_fast_q <= ref_fast;
      end
    end
  end

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PFL_EVAL: begin
        // Idle until the first window has a verdict
        if (win_end) begin
          if (!win_lock) begin
            state_d = PFL_FDET;
          end else begin
            state_d = wide_zero ? PFL_FINAL : PFL_WIDE;
          end
        end
      end
      PFL_FDET: begin
        if (win_end && win_lock) begin
          state_d = wide_zero ? PFL_FINAL : PFL_WIDE;
        end
      end
      PFL_WIDE: begin
        if (lock_sync_q[1]) begin
          state_d = PFL_FINAL;
        end
      end
      PFL_FINAL: begin
        state_d = PFL_FINAL;                                // Held until disturbed or restarted by register
      end
    endcase
    if (restart) begin
      state_d = PFL_EVAL;
    end
  end

  // ==========================================================
  // State register; one state at a time
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PFL_EVAL;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Pump outputs; detect and closed-loop groups kept apart
  // ==========================================================
  // Outputs are registered, so they trail the state by one cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fdet_en_q <= 1'b0;
      fdet_src_q <= 1'b0;
      fdet_scale_q <= 6'h00;
      cl_en_q <= 1'b0;
      cl_up_q <= 1'b0;
      cl_dn_q <= 1'b0;
      cl_scale_q <= 4'h0;
      pump_state_q <= PFL_EVAL;
    end else begin
      pump_state_q <= state_q;
      fdet_en_q <= state_q == PFL_FDET;
      fdet_src_q <= fdet_raise;
      fdet_scale_q <= (state_q == PFL_FDET) ? fdet_mult : 6'h00;
      cl_en_q <= closed;
      cl_up_q <= closed & up_dir;
      cl_dn_q <= closed & dn_dir;
      cl_scale_q <= closed ? cl_mult : 4'h0;
    end
  end
endmodule : pll_fast_lock

// *** pll_fast_lock_tb.sv ***
/*
  Self-checking bench for the fast-lock sequencer with a loop model.
  Assumes the package, the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
module pll_fast_lock_tb;
  import pfl_pkg::*;
  // ======
  // Signals
  // ======
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, fb_init = 4'h8;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, loop_disturb = 1'b0;
  logic comparator_up = 1'b0, comparator_down = 1'b0, vco_inverted = 1'b0;
  logic lock_allow = 1'b0, preset = 1'b0, saw_wide = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, pump_state_q, rr;
  logic [31:0] s_axi_rdata, rd;
  logic reference_detector_input, feedback_detector_input, phase_lock_in;
  logic fdet_en_q, fdet_src_q, cl_en_q, cl_up_q, cl_dn_q;
  logic [5:0] fdet_scale_q;
  logic [3:0] cl_scale_q;
  int num_errors = 0;
  int samples_checked = 0;
  pll_fast_lock pll_fast_lock_i (.*);
  pfl_loop_model pfl_loop_model_i (.*);
  always #5 ref_clk = ~ref_clk;
  // Remember any visit to the wide state; a disturb clears it
  always @(posedge ref_clk) saw_wide <= (pump_state_q === PFL_WIDE) | (saw_wide & ~loop_disturb);
  // ======
  // Shared tasks
  // ======
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task give_verdict;
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task timeout(input string what);
    num_errors++;
    $display("Error %s expected done seen timeout", what);
    give_verdict();
  endtask : timeout
  task axi_write(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin // Release each channel at the edge that takes it
      @(posedge ref_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) timeout("write");
    check("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask : axi_write
  task axi_read(input logic [3:0] a);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) timeout("read");
  endtask : axi_read
  // Wait for a state, then one more cycle so the outputs follow it
  task await(input logic [1:0] s, input int bound);
    int n;
    n = 0;
    while (pump_state_q !== s && n < bound) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= bound) timeout("state");
    @(posedge ref_clk);
    #1;
  endtask : await
  task steer(input logic [1:0] exp);
    @(posedge ref_clk);
    comparator_up <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("steer", {30'h0, exp}, {30'h0, cl_up_q, cl_dn_q});
    @(posedge ref_clk);
    comparator_up <= 1'b0;
    comparator_down <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    check("steer down", {30'h0, exp[0], exp[1]}, {30'h0, cl_up_q, cl_dn_q});
    @(posedge ref_clk);
    comparator_down <= 1'b0;
  endtask : steer
  // ======
  // Scenarios
  // ======
  task t_reset;
    check("idle", 32'h0, {18'h0, pump_state_q, fdet_en_q, cl_en_q, fdet_scale_q, cl_scale_q});
    axi_read(PFL_CTRL_OFS);
    check("ctrl", {24'h0, PFL_CTRL_RST}, rd);
    axi_read(PFL_TOL_OFS);
    check("tol", {27'h0, PFL_TOL_RST}, rd);
    axi_read(4'hC);
    check("bad addr", 32'h2, {rd[29:0], rr});
    axi_write(PFL_TOL_OFS, 32'h3);
    axi_read(PFL_TOL_OFS);
    check("tol rw", 32'h3, rd);
    axi_write(PFL_CTRL_OFS, 32'h69); // Final 2, wide 4, detect 60
    check("still idle", 32'h0, {18'h0, pump_state_q, fdet_en_q, cl_en_q, fdet_scale_q, cl_scale_q});
  endtask : t_reset
  task t_detect;
    await(PFL_FDET, 400);
    check("detect", 32'h1F8, {23'h0, fdet_en_q, fdet_src_q, fdet_scale_q, cl_en_q});
    await(PFL_WIDE, 4000);
    check("wide", 32'h14, {26'h0, fdet_en_q, cl_en_q, cl_scale_q});
    steer(2'b10);
    lock_allow <= 1'b1;
    await(PFL_FINAL, 20);
    check("final", 32'h12, {27'h0, cl_en_q, cl_scale_q});
    axi_read(PFL_STAT_OFS);
    check("status", 32'h3, {30'h0, rd[1:0]});
  endtask : t_detect
  task t_skip;
    @(posedge ref_clk);
    lock_allow <= 1'b0;
    fb_init <= 4'h4;
    preset <= 1'b1;
    @(posedge ref_clk);
    preset <= 1'b0;
    axi_write(PFL_CTRL_OFS, 32'h23); // No wide current
    @(posedge ref_clk);
    loop_disturb <= 1'b1;
    await(PFL_EVAL, 10);
    check("restart idle", 32'h0, {30'h0, fdet_en_q, cl_en_q});
    @(posedge ref_clk);
    loop_disturb <= 1'b0;
    await(PFL_FINAL, 400);
    check("skip wide", 32'h4, {27'h0, saw_wide, cl_scale_q});
  endtask : t_skip
  task t_polarity;
    @(posedge ref_clk);
    vco_inverted <= 1'b1;
    fb_init <= 4'hA;
    preset <= 1'b1;
    @(posedge ref_clk);
    preset <= 1'b0;
    axi_write(PFL_CTRL_OFS, 32'h1E9); // Restart with reversed polarity
    await(PFL_FDET, 400);
    check("reversed", 32'h2, {30'h0, fdet_en_q, fdet_src_q});
    await(PFL_WIDE, 4000);
    steer(2'b01);
  endtask : t_polarity
  // ======
  // Main sequence
  // ======
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_detect();
    t_skip();
    t_polarity();
    give_verdict();
  end
endmodule : pll_fast_lock_tb
